// ---- src/opc_writer.sv ----
// writer end: start notice on valid, then object sent piece by piece
// assumes the reader end shares clock and reset
`timescale 1ns/100ps
// Contract
// - valid high two cycles before any data
// - flatten object into one vector first
// - pieces are data port width
// - one piece per cycle until done
// - receiver idles until start seen
// - receiver gathers pieces until full vector
// - receiver unpacks fields in sender order
// - data width fixed at build
// - data and valid driven from registers
// - receiver only samples link wires
// - valid control only, data payload only
// - both ends share one clock
module opc_writer (
	// clock and reset
	input  wire logic            clock,
	input  wire logic            rstn,
	// requester side
	input  wire logic            send_req,
	input  wire opc_pkg::opc_obj_s send_obj,
	output logic                 send_busy,
	output logic                 send_done,
	// link
	opc_link_if.writer           link
);
	import opc_pkg::*;

	// registers
	opc_wstate_e               state_reg;
	logic [CNT_W-1:0]          cnt_reg;
	logic [VEC_W-1:0]          vec_reg;
	logic [DATA_W-1:0]         data_reg;
	logic                      valid_reg;
	logic                      busy_reg;
	logic                      done_reg;

	// next values
	opc_wstate_e               state_next;
	logic [CNT_W-1:0]          cnt_next;
	logic [VEC_W-1:0]          vec_next;
	logic [DATA_W-1:0]         data_next;
	logic                      valid_next;
	logic                      busy_next;
	logic                      done_next;
	logic [VEC_W-1:0]          flat;

	// state decode
	wire logic                 in_idle   = (state_reg == OPC_IDLE);
	wire logic                 in_start  = (state_reg == OPC_START);
	wire logic                 in_send   = (state_reg == OPC_SEND);

	// transfer events
	wire logic                 accept    = in_idle && send_req;
	wire logic                 start_end = in_start && (cnt_reg == START_LAST);
	wire logic                 last_pc   = in_send && (cnt_reg == PIECE_LAST);
	wire logic [CNT_W-1:0]     cnt_inc   = cnt_reg + 8'h01;

	// fields placed at their agreed positions, padding zero
	always_comb begin
		flat                   = '0;
		flat[TAG_POS +: TAG_W] = send_obj.tag;
		flat[LEN_POS +: LEN_W] = send_obj.length;
		flat[VAL_POS +: VAL_W] = send_obj.value;
	end

	// low piece leaves first
	wire logic [DATA_W-1:0]    low_piece = vec_reg[DATA_W-1:0];
	wire logic [VEC_W-1:0]     rest_vec  = vec_reg >> DATA_W;

	// sequencing: state and cycle counter
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			OPC_IDLE: begin
				if (accept) begin
					state_next = OPC_START;
					cnt_next   = CNT_RESET;
				end
			end
			OPC_START: begin
				if (start_end) begin
					state_next = OPC_SEND;
					cnt_next   = CNT_RESET;
				end else begin
					cnt_next   = cnt_inc;
				end
			end
			OPC_SEND: begin
				if (last_pc) begin
					state_next = OPC_IDLE;
				end else begin
					cnt_next   = cnt_inc;
				end
			end
			default: begin
				state_next = OPC_IDLE;
			end
		endcase
	end

	// link and requester outputs
	always_comb begin
		vec_next   = vec_reg;
		data_next  = DATA_RESET;
		valid_next = 1'b0;
		busy_next  = busy_reg;
		done_next  = 1'b0;
		unique case (state_reg)
			OPC_IDLE: begin
				if (accept) begin
					vec_next   = flat;
					valid_next = 1'b1;
					busy_next  = 1'b1;
				end
			end
			OPC_START: begin
				if (start_end) begin
					data_next  = low_piece;
					vec_next   = rest_vec;
				end else begin
					valid_next = 1'b1;
				end
			end
			OPC_SEND: begin
				if (last_pc) begin
					busy_next  = 1'b0;
					done_next  = 1'b1;
				end else begin
					data_next  = low_piece;
					vec_next   = rest_vec;
				end
			end
			default: begin
				busy_next  = 1'b0;
			end
		endcase
	end

	// sequencing state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= OPC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// cycle and piece counter
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= CNT_RESET;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// flattened object, shifted as pieces leave
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			vec_reg <= '0;
		end else begin
			vec_reg <= vec_next;
		end
	end

	// data bus register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			data_reg <= DATA_RESET;
		end else begin
			data_reg <= data_next;
		end
	end

	// valid line register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= valid_next;
		end
	end

	// busy flag
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= busy_next;
		end
	end

	// done pulse
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= done_next;
		end
	end

	// outputs straight from registers
	assign link.data_lines = data_reg;
	assign link.valid_line = valid_reg;
	assign send_busy       = busy_reg;
	assign send_done       = done_reg;
endmodule

// ---- src/opc_pkg.sv ----
// constants shared by the object channel writer and reader ends
// assumes both ends are elaborated with this package and one clock
package opc_pkg;
	localparam int DATA_W   = 8;
	localparam int OBJ_W    = 40;
	localparam int PIECES   = (OBJ_W + DATA_W - 1) / DATA_W;
	localparam int VEC_W    = PIECES * DATA_W;
	localparam int START_CYCLES = 2;
	localparam int CNT_W    = 8;
	localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_CYCLES - 1);
	localparam logic [CNT_W-1:0] PIECE_LAST = CNT_W'(PIECES - 1);
	localparam logic [CNT_W-1:0] CNT_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

	// object layout: fields packed low to high
	localparam int TAG_POS  = 0;
	localparam int TAG_W    = 8;
	localparam int LEN_POS  = 8;
	localparam int LEN_W    = 16;
	localparam int VAL_POS  = 24;
	localparam int VAL_W    = 16;

	typedef struct packed {
		logic [VAL_W-1:0] value;
		logic [LEN_W-1:0] length;
		logic [TAG_W-1:0] tag;
	} opc_obj_s;

	typedef enum logic [1:0] {
		OPC_IDLE  = 2'b00,
		OPC_START = 2'b01,
		OPC_SEND  = 2'b10
	} opc_wstate_e;

	typedef enum logic [1:0] {
		OPC_R_IDLE  = 2'b00,
		OPC_R_START = 2'b01,
		OPC_R_GATH  = 2'b10
	} opc_rstate_e;
endpackage

// ---- src/opc_link_if.sv ----
// shared wires between the writer and reader ends
// assumes both ends share one clock
`timescale 1ns/100ps
interface opc_link_if;
	logic [opc_pkg::DATA_W-1:0] data_lines;
	logic                       valid_line;

	modport writer (
		output data_lines,
		output valid_line
	);
	modport reader (
		input data_lines,
		input valid_line
	);
endinterface

// ---- src/opc_reader.sv ----
// reader end: waits for start notice, gathers pieces, rebuilds object
// assumes the writer end shares clock and reset
`timescale 1ns/100ps
module opc_reader (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	// consumer side
	output opc_pkg::opc_obj_s      recv_obj,
	output logic                   recv_valid,
	// link
	opc_link_if.reader             link
);
	import opc_pkg::*;

	opc_rstate_e               state_reg, state_next;
	logic [CNT_W-1:0]          cnt_reg, cnt_next;
	logic [VEC_W-1:0]          vec_reg, vec_next;
	opc_obj_s                  obj_reg, obj_next;
	logic                      rv_reg, rv_next;

	wire logic [VEC_W-1:0]     shifted = {link.data_lines, vec_reg[VEC_W-1:DATA_W]};
	wire logic                 fall    = (state_reg == OPC_R_START) && !link.valid_line;
	// first piece already counted in the start state
	wire logic                 last_pc = (state_reg == OPC_R_GATH) && (cnt_reg == PIECE_LAST - 8'h01);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		vec_next   = vec_reg;
		obj_next   = obj_reg;
		rv_next    = 1'b0;
		unique case (state_reg)
			OPC_R_IDLE: begin
				if (link.valid_line) begin
					state_next = OPC_R_START;
				end
			end
			OPC_R_START: begin
				// first piece rides with valid low
				if (fall) begin
					state_next = OPC_R_GATH;
					vec_next   = shifted;
					cnt_next   = CNT_RESET;
					if (PIECE_LAST == CNT_RESET) begin
						state_next = OPC_R_IDLE;
						obj_next   = opc_obj_s'(shifted[OBJ_W-1:0]);
						rv_next    = 1'b1;
					end
				end
			end
			OPC_R_GATH: begin
				vec_next = shifted;
				cnt_next = cnt_reg + 8'h01;
				if (last_pc) begin
					state_next = OPC_R_IDLE;
					obj_next   = opc_obj_s'(shifted[OBJ_W-1:0]);
					rv_next    = 1'b1;
				end
			end
			default: state_next = OPC_R_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= OPC_R_IDLE;
			cnt_reg   <= CNT_RESET;
			vec_reg   <= '0;
			obj_reg   <= '0;
			rv_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			vec_reg   <= vec_next;
			obj_reg   <= obj_next;
			rv_reg    <= rv_next;
		end
	end

	assign recv_obj   = obj_reg;
	assign recv_valid = rv_reg;
endmodule

// ---- verif/opc_checker.sv ----
// link checker: start notice and payload framing on the shared wires
// assumes one clock and the link signals handed in as plain inputs
`timescale 1ns/100ps
module opc_checker (
	// clock and reset
	input wire logic                       clock,
	input wire logic                       rstn,
	// link
	input wire logic [opc_pkg::DATA_W-1:0] data_lines,
	input wire logic                       valid_line
);
	import opc_pkg::*;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	chk_valid_second_high: assert property ($rose(valid_line) |=> valid_line)
		else $error("start notice too short");
	chk_valid_third_low: assert property (valid_line ##1 valid_line |=> !valid_line)
		else $error("start notice too long");
	chk_fall_after_two: assert property ($fell(valid_line) |-> $past(valid_line, 2))
		else $error("start notice fell early");
	chk_valid_quiet_send: assert property ($fell(valid_line) |-> !valid_line [*6])
		else $error("valid during payload");
	chk_data_quiet_start: assert property (valid_line |-> data_lines == 8'h00)
		else $error("data during start notice");
	chk_data_zero_before: assert property ($rose(valid_line) |-> $past(data_lines) == 8'h00)
		else $error("data before start");
	chk_data_ends_five: assert property ($fell(valid_line) |-> ##5 data_lines == 8'h00)
		else $error("piece count wrong");
	chk_start_spacing: assert property ($rose(valid_line) |=> !$rose(valid_line) [*7])
		else $error("new start too soon");
	cover property ($rose(valid_line));
	cover property ($fell(valid_line) ##6 $rose(valid_line));
	cover property (data_lines == 8'hFF);
endmodule

// ---- verif/tb_object_p2p_channel.sv ----
// bench: writer and reader ends joined by the link, objects sent end to end
// assumes the package, link, both ends and the checker are compiled first
`timescale 1ns/100ps
module tb_object_p2p_channel;
	import opc_pkg::*;
	logic     clock;
	logic     rstn;
	logic     send_req;
	opc_obj_s send_obj;
	logic     send_busy;
	logic     send_done;
	opc_obj_s recv_obj;
	logic     recv_valid;
	int       n_errors = 0;
	int       comparisons = 0;
	opc_obj_s objs [3] = '{40'h0123456789, 40'hFFFFFFFFFF, 40'h8000000001};

	opc_link_if u_opc_link_if ();
	opc_writer u_opc_writer (.clock(clock), .rstn(rstn), .send_req(send_req), .send_obj(send_obj),
		.send_busy(send_busy), .send_done(send_done), .link(u_opc_link_if));
	opc_reader u_opc_reader (.clock(clock), .rstn(rstn), .recv_obj(recv_obj), .recv_valid(recv_valid),
		.link(u_opc_link_if));
	opc_checker u_opc_checker (.clock(clock), .rstn(rstn), .data_lines(u_opc_link_if.data_lines),
		.valid_line(u_opc_link_if.valid_line));

	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// entered 1 ns after an edge; request held one edge, returns in the done cycle
	task automatic xfer(input opc_obj_s o);
		send_req = 1'b1;
		send_obj = o;
		@(posedge clock);
		#1 send_req = 1'b0;
		chk("done early", 2'b00, {send_done, recv_valid});
		for (int i = 1; i < 8; i++) begin
			chk("busy", 1'b1, send_busy);
			chk("valid", i < 3, u_opc_link_if.valid_line);
			if (i > 2) chk("piece", o[(i-3)*8 +: 8], u_opc_link_if.data_lines);
			@(posedge clock);
			#1;
		end
		chk("done", 2'b11, {send_done, recv_valid});
		chk("object", o, recv_obj);
		chk("idle", 1'b0, send_busy);
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		repeat (200) @(posedge clock);
		n_errors++;
		report_and_stop();
	end

	initial begin
		rstn = 1'b0;
		send_req = 1'b0;
		send_obj = '0;
		repeat (6) @(posedge clock);
		#1 rstn = 1'b1;
		// back to back: each request after the first raised in the previous done cycle
		for (int k = 0; k < 3; k++) begin
			xfer(objs[k]);
			$display("test %0d done", k);
		end
		@(posedge clock);
		#1;
		chk("pulse end", 2'b00, {send_done, recv_valid});
		chk("held", objs[2], recv_obj);
		report_and_stop();
	end
endmodule
